// file: csfc_defines.svh
// constants for the checksum unit and its processor-side controller
`ifndef CSFC_DEFINES_SVH
`define CSFC_DEFINES_SVH
`define CSFC_POLY 16'h1021
`define CSFC_SEED_ONES 16'hffff
`define CSFC_SEED_ZERO 16'h0000
`define CSFC_BLOCK_SHIFT 8
`define CSFC_BITS_PER_BYTE 4'h8
// device register addresses
`define CSFC_ADDR_AUTO 8'hc9
`define CSFC_ADDR_DATA_IN 8'hca
`define CSFC_ADDR_RESULT 8'hcb
`define CSFC_ADDR_FLIP 8'hcc
`define CSFC_ADDR_START 8'hcd
`define CSFC_ADDR_CTRL 8'hce
// control and auto-config field positions
`define CSFC_CTRL_INIT 3
`define CSFC_CTRL_SEED 2
`define CSFC_CTRL_PTR 0
`define CSFC_AUTO_EN 7
`define CSFC_CNT_W 6
// controller software register addresses
`define CSFC_SW_TADDR 4'h0
`define CSFC_SW_TDATA 4'h1
`define CSFC_SW_CMD 4'h2
`define CSFC_SW_STATUS 4'h3
`define CSFC_SW_RDATA 4'h4
`define CSFC_SW_MEM_PAGE 4'h5
`define CSFC_SW_MEM_DATA 4'h6
`define CSFC_CMD_WR 0
`define CSFC_CMD_RD 1
`define CSFC_GUARD_CYCLES 2'h3
`endif

// file: csfc_pkg.sv
// types and datapath functions for the checksum unit
`include "csfc_defines.svh"
package csfc_pkg;
  typedef enum logic [1:0] {
    CSFC_IDLE = 2'b00,
    CSFC_FETCH = 2'b01,
    CSFC_DRAIN = 2'b10
  } csfc_auto_st_t;

  // one shift step of the checksum
  function automatic logic [15:0] csfc_crc_step(input logic [15:0] v);
    csfc_crc_step = v[15] ? ({v[14:0], 1'b0} ^ `CSFC_POLY) : {v[14:0], 1'b0};
  endfunction : csfc_crc_step

  function automatic logic [7:0] csfc_bit_rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      csfc_bit_rev[i] = b[7 - i];
    end
  endfunction : csfc_bit_rev
endpackage : csfc_pkg

// file: csfc_link_if.sv
// register and code-fetch link between processor side and checksum unit
interface csfc_link_if;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  logic sfr_ack;
  logic [7:0] sfr_rdata;
  logic cpu_stall;
  logic code_rd;
  logic [15:0] code_addr;
  logic [7:0] code_rdata;

  modport dev (
    input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, code_rdata,
    output sfr_ack, sfr_rdata, cpu_stall, code_rd, code_addr
  );
  modport host (
    output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, code_rdata,
    input sfr_ack, sfr_rdata, cpu_stall, code_rd, code_addr
  );
endinterface : csfc_link_if

// file: csfc_fifo2.sv
// small valid/ready buffer in front of the checksum engine
module csfc_fifo2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset
  input wire logic ce, // clock enable
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [W-1:0] out_data // word out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : next_ptr

  assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        wp_r <= next_ptr(wp_r);
      end
      if (pop) begin
        rp_r <= next_ptr(rp_r);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : csfc_fifo2

// file: csfc_checksum_unit.sv
// checksum unit: register set, bytewise engine, automatic code check
`include "csfc_defines.svh"
module csfc_checksum_unit
  import csfc_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset
  input wire logic ce, // clock enable
  csfc_link_if.dev link // processor-side link
);
  logic [15:0] crc_r;
  logic [3:0] bits_r;
  logic seed_r;
  logic ptr_r;
  logic [7:0] flip_r;
  logic [7:0] start_page_r;
  logic auto_en_r;
  logic [`CSFC_CNT_W-1:0] blocks_r;
  csfc_auto_st_t st_r;
  logic [15:0] fetch_addr_r;
  logic [`CSFC_CNT_W+8:0] remain_r;
  logic pending_r;
  logic ack_r;
  logic [7:0] rdata_r;
  logic stall_r;
  logic code_rd_r;
  logic code_take_r;

  logic req;
  logic take;
  logic can;
  logic hit_data;
  logic needs_idle;
  logic engine_idle;
  logic wr_take;
  logic rd_take;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [7:0] buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;
  logic [7:0] rd_mux;

  assign req = (link.sfr_wr || link.sfr_rd) && !ack_r;
  assign hit_data = (link.sfr_addr == `CSFC_ADDR_DATA_IN);
  assign needs_idle = (link.sfr_addr == `CSFC_ADDR_CTRL) ||
                      (link.sfr_addr == `CSFC_ADDR_RESULT);
  assign engine_idle = (bits_r == '0) && !buf_out_valid;

  // refuse accesses while code check runs; control and result accesses also wait for an idle engine, data writes for buffer room
  always_comb begin
    can = 1'b0;
    if (st_r == CSFC_IDLE) begin
      if (link.sfr_wr && hit_data) begin
        can = buf_in_ready;
      end else if (needs_idle) begin
        can = engine_idle;
      end else begin
        can = 1'b1;
      end
    end
  end

  assign take = req && can;
  assign wr_take = take && link.sfr_wr;
  assign rd_take = take && link.sfr_rd && !link.sfr_wr;

  // software bytes and fetched code bytes share one path
  // fetched byte arrives one cycle after the fetch pulse
  assign buf_in_valid = (wr_take && hit_data) || code_take_r;
  assign buf_in_data = code_take_r ? link.code_rdata : link.sfr_wdata;
  assign buf_out_ready = (bits_r == '0);

  csfc_fifo2 #(
    .W(8),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // engine: merge byte and do first step, then seven more
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_r <= `CSFC_SEED_ZERO;
      bits_r <= '0;
    end else if (ce) begin
      if (wr_take && link.sfr_addr == `CSFC_ADDR_CTRL && link.sfr_wdata[`CSFC_CTRL_INIT]) begin
        crc_r <= link.sfr_wdata[`CSFC_CTRL_SEED] ? `CSFC_SEED_ONES : `CSFC_SEED_ZERO;
      end else if (bits_r != '0) begin
        crc_r <= csfc_crc_step(crc_r);
        bits_r <= bits_r - 1'b1;
      end else if (buf_out_valid) begin
        crc_r <= csfc_crc_step(crc_r ^ {buf_out_data, 8'h00});
        bits_r <= `CSFC_BITS_PER_BYTE - 1'b1;
      end
    end
  end

  // control, pointer and configuration fields
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seed_r <= 1'b0;
      ptr_r <= 1'b0;
      flip_r <= 8'h00;
      start_page_r <= 8'h00;
      auto_en_r <= 1'b0;
      blocks_r <= '0;
    end else if (ce) begin
      if (wr_take) begin
        case (link.sfr_addr)
          `CSFC_ADDR_CTRL: begin
            seed_r <= link.sfr_wdata[`CSFC_CTRL_SEED];
            ptr_r <= link.sfr_wdata[`CSFC_CTRL_PTR];
          end
          `CSFC_ADDR_FLIP: flip_r <= csfc_bit_rev(link.sfr_wdata);
          `CSFC_ADDR_START: start_page_r <= link.sfr_wdata;
          `CSFC_ADDR_AUTO: begin
            auto_en_r <= link.sfr_wdata[`CSFC_AUTO_EN];
            blocks_r <= link.sfr_wdata[`CSFC_CNT_W-1:0];
          end
          default: begin
          end
        endcase
      end else if (rd_take && link.sfr_addr == `CSFC_ADDR_RESULT) begin
        ptr_r <= ~ptr_r;
      end
    end
  end

  // read data, valid only in the cycle after the access is taken
  always_comb begin
    case (link.sfr_addr)
      `CSFC_ADDR_CTRL: rd_mux = {4'h0, 1'b0, seed_r, 1'b0, ptr_r};
      `CSFC_ADDR_RESULT: rd_mux = ptr_r ? crc_r[15:8] : crc_r[7:0];
      `CSFC_ADDR_FLIP: rd_mux = flip_r;
      `CSFC_ADDR_START: rd_mux = start_page_r;
      `CSFC_ADDR_AUTO: rd_mux = {auto_en_r, 1'b0, blocks_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (ce) begin
      ack_r <= take;
      rdata_r <= rd_take ? rd_mux : 8'h00;
    end
  end

  // automatic code check sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= CSFC_IDLE;
      fetch_addr_r <= 16'h0000;
      remain_r <= '0;
      pending_r <= 1'b0;
      code_rd_r <= 1'b0;
      code_take_r <= 1'b0;
      stall_r <= 1'b0;
    end else if (ce) begin
      code_rd_r <= 1'b0;
      code_take_r <= code_rd_r;
      case (st_r)
        CSFC_IDLE: begin
          if (wr_take && link.sfr_addr == `CSFC_ADDR_CTRL && auto_en_r) begin
            fetch_addr_r <= {start_page_r, 8'h00};
            remain_r <= {1'b0, blocks_r, 8'h00};
            stall_r <= 1'b1;
            st_r <= (blocks_r == '0) ? CSFC_DRAIN : CSFC_FETCH;
          end
        end
        CSFC_FETCH: begin
          if (pending_r) begin
            // room was checked at issue; hold off until the byte is pushed
            if (code_take_r) begin
              pending_r <= 1'b0;
            end
          end else if (remain_r == '0) begin
            st_r <= CSFC_DRAIN;
          end else if (buf_in_ready) begin
            code_rd_r <= 1'b1;
            pending_r <= 1'b1;
            fetch_addr_r <= fetch_addr_r + 16'h0001;
            remain_r <= remain_r - 1'b1;
          end
        end
        CSFC_DRAIN: begin
          if (engine_idle) begin
            stall_r <= 1'b0;
            st_r <= CSFC_IDLE;
          end
        end
        default: begin
          st_r <= CSFC_IDLE;
          stall_r <= 1'b0;
        end
      endcase
    end
  end

  // address stands one byte behind the advanced counter
  logic [15:0] code_addr_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_addr_r <= 16'h0000;
    end else if (ce && st_r == CSFC_FETCH && !pending_r && remain_r != '0 && buf_in_ready) begin
      code_addr_r <= fetch_addr_r;
    end
  end

  assign link.sfr_ack = ack_r;
  assign link.sfr_rdata = rdata_r;
  assign link.cpu_stall = stall_r;
  assign link.code_rd = code_rd_r;
  assign link.code_addr = code_addr_r;
endmodule : csfc_checksum_unit

// file: csfc_cpu_port.sv
// processor-side end: software command registers, code memory, link master
`include "csfc_defines.svh"
module csfc_cpu_port
  import csfc_pkg::*;
#(
  parameter int CODE_AW = 10
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset
  input wire logic ce, // clock enable
  input wire logic [3:0] sw_addr, // software register address
  input wire logic [7:0] sw_wdata, // software write data
  input wire logic sw_wr, // software write strobe
  input wire logic sw_rd, // software read strobe
  output logic [7:0] sw_rdata, // read data, cycle after strobe
  csfc_link_if.host link // link to checksum unit
);
  logic [7:0] code_mem [2**CODE_AW];
  logic [CODE_AW-1:0] mem_ptr_r;
  logic [7:0] taddr_r;
  logic [7:0] tdata_r;
  logic wr_r;
  logic rd_r;
  logic last_rd_r;
  logic [7:0] got_r;
  logic [1:0] guard_r;
  logic [7:0] sw_rdata_r;
  logic [7:0] code_rdata_r;
  logic busy;
  logic issue;

  assign busy = wr_r || rd_r;
  // no new access during stall or the settling cycles after a control write
  assign issue = ce && sw_wr && sw_addr == `CSFC_SW_CMD && !busy && guard_r == '0
                 && !link.cpu_stall;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      taddr_r <= 8'h00;
      tdata_r <= 8'h00;
      mem_ptr_r <= '0;
    end else if (ce && sw_wr) begin
      case (sw_addr)
        `CSFC_SW_TADDR: taddr_r <= sw_wdata;
        `CSFC_SW_TDATA: tdata_r <= sw_wdata;
        `CSFC_SW_MEM_PAGE: mem_ptr_r <= CODE_AW'({sw_wdata, 8'h00});
        `CSFC_SW_MEM_DATA: mem_ptr_r <= mem_ptr_r + 1'b1;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (ce && sw_wr && sw_addr == `CSFC_SW_MEM_DATA) begin
      code_mem[mem_ptr_r] <= sw_wdata;
    end
  end

  // strobes held until the unit acknowledges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      last_rd_r <= 1'b0;
      got_r <= 8'h00;
      guard_r <= '0;
    end else if (ce) begin
      if (issue) begin
        wr_r <= sw_wdata[`CSFC_CMD_WR];
        rd_r <= sw_wdata[`CSFC_CMD_RD] && !sw_wdata[`CSFC_CMD_WR];
      end else if (link.sfr_ack) begin
        wr_r <= 1'b0;
        rd_r <= 1'b0;
        last_rd_r <= rd_r;
        if (rd_r) begin
          got_r <= link.sfr_rdata;
        end
      end
      if (link.sfr_ack && wr_r && taddr_r == `CSFC_ADDR_CTRL) begin
        guard_r <= `CSFC_GUARD_CYCLES;
      end else if (guard_r != '0) begin
        guard_r <= guard_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_rdata_r <= 8'h00;
    end else if (ce && link.code_rd) begin
      code_rdata_r <= code_mem[link.code_addr[CODE_AW-1:0]];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_rdata_r <= 8'h00;
    end else if (ce) begin
      sw_rdata_r <= 8'h00;
      if (sw_rd) begin
        case (sw_addr)
          `CSFC_SW_TADDR: sw_rdata_r <= taddr_r;
          `CSFC_SW_TDATA: sw_rdata_r <= tdata_r;
          `CSFC_SW_STATUS: sw_rdata_r <= {4'h0, last_rd_r, guard_r != '0, link.cpu_stall, busy};
          `CSFC_SW_RDATA: sw_rdata_r <= got_r;
          default: sw_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign sw_rdata = sw_rdata_r;
  assign link.sfr_addr = taddr_r;
  assign link.sfr_wdata = tdata_r;
  assign link.sfr_wr = wr_r;
  assign link.sfr_rd = rd_r;
  assign link.code_rdata = code_rdata_r;
endmodule : csfc_cpu_port

// file: csfc_link_asserts.sv
// reference checksum package and link checker for the checksum unit
`include "csfc_defines.svh"
package csfc_tb_pkg;
  function automatic logic [15:0] csfc_tb_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      v = v[15] ? ({v[14:0], 1'b0} ^ 16'h1021) : {v[14:0], 1'b0};
    end
    return v;
  endfunction : csfc_tb_crc
endpackage : csfc_tb_pkg

module csfc_link_asserts
  import csfc_tb_pkg::*;
(
  input logic clk, // system clock
  input logic reset_n, // async reset
  input logic [7:0] sfr_addr, // target address
  input logic [7:0] sfr_wdata, // write data
  input logic sfr_wr, // write strobe
  input logic sfr_rd, // read strobe
  input logic sfr_ack, // access taken
  input logic [7:0] sfr_rdata, // read data
  input logic cpu_stall, // processor stall
  input logic code_rd, // fetch pulse
  input logic [15:0] code_addr, // fetch address
  input logic [7:0] code_rdata // fetched byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] crc_r;
  logic ptr_r;
  logic auto_en_r;
  logic [5:0] cnt_r;
  logic [7:0] start_r;
  logic [7:0] flip_r;
  logic [7:0] rev;
  logic [15:0] next_r;
  logic [15:0] fetch_r;
  logic take_r;
  logic wr_ack;
  logic rd_ack;
  assign wr_ack = sfr_ack && sfr_wr;
  assign rd_ack = sfr_ack && sfr_rd;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rev[i] = flip_r[7 - i];
    end
  end
  // reference result and byte pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_r <= 16'h0000;
      ptr_r <= 1'b0;
    end else if (wr_ack && sfr_addr == `CSFC_ADDR_CTRL) begin
      ptr_r <= sfr_wdata[0];
      if (sfr_wdata[3]) begin
        crc_r <= sfr_wdata[2] ? 16'hffff : 16'h0000;
      end
    end else if (wr_ack && sfr_addr == `CSFC_ADDR_DATA_IN) begin
      crc_r <= csfc_tb_crc(crc_r, sfr_wdata);
    end else if (take_r) begin
      crc_r <= csfc_tb_crc(crc_r, code_rdata);
    end else if (rd_ack && sfr_addr == `CSFC_ADDR_RESULT) begin
      ptr_r <= ~ptr_r;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_en_r <= 1'b0;
      cnt_r <= 6'h00;
      start_r <= 8'h00;
      flip_r <= 8'h00;
    end else if (wr_ack && sfr_addr == `CSFC_ADDR_AUTO) begin
      auto_en_r <= sfr_wdata[7];
      cnt_r <= sfr_wdata[5:0];
    end else if (wr_ack && sfr_addr == `CSFC_ADDR_START) begin
      start_r <= sfr_wdata;
    end else if (wr_ack && sfr_addr == `CSFC_ADDR_FLIP) begin
      flip_r <= sfr_wdata;
    end
  end
  // expected fetch address and count of a run
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      take_r <= 1'b0;
      next_r <= 16'h0000;
      fetch_r <= 16'h0000;
    end else begin
      take_r <= code_rd;
      if (wr_ack && sfr_addr == `CSFC_ADDR_CTRL && auto_en_r) begin
        next_r <= {start_r, 8'h00};
        fetch_r <= 16'h0000;
      end else if (code_rd) begin
        next_r <= next_r + 16'h0001;
        fetch_r <= fetch_r + 16'h0001;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_ack_pulse; sfr_ack |=> !sfr_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_rdata_idle; !rd_ack |-> sfr_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  property p_result;
    rd_ack && sfr_addr == `CSFC_ADDR_RESULT |-> sfr_rdata == (ptr_r ? crc_r[15:8] : crc_r[7:0]);
  endproperty
  a_result: assert property (p_result) else $error("result byte wrong");
  property p_ctrl;
    rd_ack && sfr_addr == `CSFC_ADDR_CTRL |-> sfr_rdata[7:3] == 5'h00 && !sfr_rdata[1]
      && sfr_rdata[0] == ptr_r;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read wrong");
  property p_flip; rd_ack && sfr_addr == `CSFC_ADDR_FLIP |-> sfr_rdata == rev; endproperty
  a_flip: assert property (p_flip) else $error("reversed byte wrong");
  property p_start; wr_ack && sfr_addr == `CSFC_ADDR_CTRL && auto_en_r |-> cpu_stall; endproperty
  a_start: assert property (p_start) else $error("run did not stall");
  property p_fetch_stall; code_rd |-> cpu_stall; endproperty
  a_fetch_stall: assert property (p_fetch_stall) else $error("fetch without stall");
  property p_fetch_gap; code_rd |=> !code_rd; endproperty
  a_fetch_gap: assert property (p_fetch_gap) else $error("fetches too close");
  property p_fetch_addr; code_rd |-> code_addr == next_r; endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
  property p_count; $fell(cpu_stall) |-> fetch_r == {2'b00, cnt_r, 8'h00}; endproperty
  a_count: assert property (p_count) else $error("fetch count wrong");
  c_run: cover property ($rose(cpu_stall));
  c_fetch: cover property (code_rd);
  c_result: cover property (rd_ack && sfr_addr == `CSFC_ADDR_RESULT);
  c_flip: cover property (rd_ack && sfr_addr == `CSFC_ADDR_FLIP);
endmodule : csfc_link_asserts

// file: crc16_stream_and_flash_checker_test.sv
// testbench: both ends joined, driven through the software port
`include "csfc_defines.svh"
module crc16_stream_and_flash_checker_test
  import csfc_tb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  int fail_count = 0;
  int samples_checked = 0;
  csfc_link_if link ();
  csfc_checksum_unit #(.BUF_DEPTH(2)) i_csfc_checksum_unit (
    .clk(clk), .reset_n(reset_n), .ce(ce), .link(link));
  csfc_cpu_port #(.CODE_AW(10)) i_csfc_cpu_port (.clk(clk), .reset_n(reset_n), .ce(ce),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .link(link));
  csfc_link_asserts i_csfc_link_asserts (.clk(clk), .reset_n(reset_n),
    .sfr_addr(link.sfr_addr), .sfr_wdata(link.sfr_wdata), .sfr_wr(link.sfr_wr),
    .sfr_rd(link.sfr_rd), .sfr_ack(link.sfr_ack), .sfr_rdata(link.sfr_rdata),
    .cpu_stall(link.cpu_stall), .code_rd(link.code_rd), .code_addr(link.code_addr),
    .code_rdata(link.code_rdata));
  always #10 clk = ~clk;

  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  // idle twice in a row, then outlast the guard after control writes
  task automatic wait_idle();
    logic [7:0] s;
    int n;
    n = 0;
    for (int i = 0; i < 4000; i++) begin
      sw_read(`CSFC_SW_STATUS, s);
      n = (s[1:0] === 2'b00) ? n + 1 : 0;
      if (n == 2) begin
        repeat (4) @(posedge clk);
        return;
      end
    end
    fail_count++;
    report_and_stop();
  endtask : wait_idle
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    sw_write(`CSFC_SW_TADDR, a);
    sw_write(`CSFC_SW_TDATA, d);
    sw_write(`CSFC_SW_CMD, 8'h01);
    wait_idle();
  endtask : dev_wr
  task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
    sw_write(`CSFC_SW_TADDR, a);
    sw_write(`CSFC_SW_CMD, 8'h02);
    wait_idle();
    sw_read(`CSFC_SW_RDATA, d);
  endtask : dev_rd
  task automatic read_result(output logic [15:0] r);
    logic [7:0] lo;
    logic [7:0] hi;
    dev_rd(`CSFC_ADDR_RESULT, lo);
    dev_rd(`CSFC_ADDR_RESULT, hi);
    r = {hi, lo};
  endtask : read_result

  task automatic t_reset();
    logic [7:0] d;
    logic [15:0] r;
    dev_rd(`CSFC_ADDR_CTRL, d);
    check("ctrl_reset", {8'h00, d}, 16'h0000);
    read_result(r);
    check("result_reset", r, 16'h0000);
  endtask : t_reset
  task automatic t_table();
    logic [39:0] ins [5] = '{40'h63, 40'h8c, 40'h7d, 40'haabbcc, 40'h0000aabbcc};
    int lens [5] = '{1, 1, 1, 3, 5};
    logic [15:0] outs [5] = '{16'hbd35, 16'hb1f4, 16'h4eca, 16'h6cf6, 16'hb166};
    logic [15:0] r;
    for (int k = 0; k < 5; k++) begin
      dev_wr(`CSFC_ADDR_CTRL, 8'h0c);
      for (int j = lens[k] - 1; j >= 0; j--) begin
        dev_wr(`CSFC_ADDR_DATA_IN, ins[k][8 * j +: 8]);
      end
      read_result(r);
      check("table", r, outs[k]);
    end
  endtask : t_table
  task automatic t_seed_ptr();
    logic [7:0] d;
    logic [15:0] r;
    dev_wr(`CSFC_ADDR_CTRL, 8'h08);
    dev_wr(`CSFC_ADDR_DATA_IN, 8'h63);
    dev_wr(`CSFC_ADDR_CTRL, 8'h01);
    dev_rd(`CSFC_ADDR_RESULT, d);
    check("ptr_high", {8'h00, d}, 16'h005c);
    dev_rd(`CSFC_ADDR_RESULT, d);
    check("ptr_next", {8'h00, d}, 16'h00c5);
    dev_rd(`CSFC_ADDR_CTRL, d);
    check("ctrl_ptr", {8'h00, d}, 16'h0001);
    dev_wr(`CSFC_ADDR_CTRL, 8'hf4);
    dev_rd(`CSFC_ADDR_CTRL, d);
    check("ctrl_reserved", {8'h00, d}, 16'h0004);
    dev_wr(`CSFC_ADDR_CTRL, 8'h0c);
    read_result(r);
    check("seed_ones", r, 16'hffff);
  endtask : t_seed_ptr
  task automatic t_flip();
    logic [15:0] pairs [3] = '{16'hc003, 16'h1e78, 16'h0180};
    logic [7:0] d;
    for (int k = 0; k < 3; k++) begin
      dev_wr(`CSFC_ADDR_FLIP, pairs[k][15:8]);
      dev_rd(`CSFC_ADDR_FLIP, d);
      check("flip", {8'h00, d}, {8'h00, pairs[k][7:0]});
    end
  endtask : t_flip
  task automatic t_auto();
    logic [15:0] exp;
    logic [15:0] r;
    exp = 16'hffff;
    sw_write(`CSFC_SW_MEM_PAGE, 8'h01);
    for (int i = 0; i < 512; i++) begin
      sw_write(`CSFC_SW_MEM_DATA, 8'(i * 7 + 3));
      exp = csfc_tb_crc(exp, 8'(i * 7 + 3));
    end
    dev_wr(`CSFC_ADDR_CTRL, 8'h0c);
    dev_wr(`CSFC_ADDR_START, 8'h01);
    dev_wr(`CSFC_ADDR_AUTO, 8'h82);
    dev_wr(`CSFC_ADDR_CTRL, 8'h00);
    dev_wr(`CSFC_ADDR_AUTO, 8'h00);
    read_result(r);
    check("auto_two_blocks", r, exp);
    dev_wr(`CSFC_ADDR_AUTO, 8'h80);
    dev_wr(`CSFC_ADDR_CTRL, 8'h00);
    dev_wr(`CSFC_ADDR_AUTO, 8'h00);
    read_result(r);
    check("auto_zero_blocks", r, exp);
  endtask : t_auto

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_table();
    t_seed_ptr();
    t_flip();
    t_auto();
    report_and_stop();
  end
endmodule : crc16_stream_and_flash_checker_test
